// >>> src/bclb_pkg.sv
/*
   Package for the device control register low byte: bit positions,
   reset value, filter count and the packed carriers of the block.
   Assumes a single 200 MHz logic clock.
*/
package bclb_pkg;
   // ****************************************
   // Bit positions
   // ****************************************
   localparam int unsigned BIT_OL_CHECK = 7;
   localparam int unsigned BIT_OL_THRESH = 6;
   localparam int unsigned BIT_PUMP_POLICY = 5;
   localparam int unsigned BIT_DITHER_DIS = 4;
   localparam int unsigned BIT_OV_SELECT = 3;
   localparam int unsigned BIT_PARITY = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] WRITE_MASK = 8'hF8;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned PUMP_FILTER_NS = 1000;
   localparam int unsigned PUMP_FILTER_CYC =
      (PUMP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FILT_W = 8;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic wr;
      logic [7:0] wdata;
      logic rd;
      logic clr_pump_flag;
   } bclb_access_t;

   typedef struct packed {
      logic ol_check_active;
      logic ol_thresh_sel;
      logic dither_disable;
      logic ov_thresh_sel;
      logic outputs_allowed;
   } bclb_ctrl_t;
endpackage

// >>> src/bclb_ctrl_low.sv
/*
   Device control register low byte with charge pump undervoltage
   flag policy and output gating.
   Assumes the serial frame decoder delivers one-cycle write, read and
   flag-clear strobes synchronous to ref_clk_i; pump comparator is
   already synchronous.
*/
// Behaviour
// RL1: Open-load check honoured only while output enable bit is clear.
// RL2: Bit 6 selects off-state comparator threshold, one option one sixth.
// RL3: Policy set: undervoltage flag follows current pump condition, read-only.
// RL4: Policy set: outputs return automatically when pump recovers.
// RL5: Policy clear: undervoltage flag latches until a clearing access.
// RL6: Policy clear: outputs stay off until latched flag is cleared.
// RL7: Latched mode: recovery filtered above threshold, then host clear re-enables.
// RL8: Bit 4 set disables pump dithering; clear keeps dithering.
// RL9: Bit 3 selects first or second overvoltage threshold pair.
// RL10: Output enable bit writable only per fail-safe pin and watchdog flag.
// RL11: Bits 2 and 1 read zero and ignore writes.
// RL12: Bit 0 is parity: computed on reads, checked on writes.
module bclb_ctrl_low #(
   parameter int unsigned FILTER_CYC = bclb_pkg::PUMP_FILTER_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire bclb_pkg::bclb_access_t access_i,
   input wire logic output_enable_bit_i,
   input wire logic failsafe_input_n_i,
   input wire logic watchdog_fault_flag_i,
   input wire logic pump_low_i,
   output logic [7:0] rdata_o,
   output logic parity_error_o,
   output logic pump_undervoltage_flag_o,
   output logic output_enable_writable_o,
   output bclb_pkg::bclb_ctrl_t ctrl_o
);
   import bclb_pkg::*;

   // ****************************************
   // State
   // ****************************************
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic latched_flag;
   logic next_latched_flag;
   logic [FILT_W-1:0] filt_cnt;
   logic [FILT_W-1:0] next_filt_cnt;
   logic recovered;
   logic wr_ok;
   logic [7:0] next_rdata;
   logic next_parity_error;

   // Odd parity bit over the seven upper bits
   function automatic logic odd_parity(input logic [6:0] d);
      return ~(^d);
   endfunction

   assign recovered = (filt_cnt >= FILTER_CYC[FILT_W-1:0]);
   // Parity of write frame must match before anything is stored
   assign wr_ok = access_i.wr && (access_i.wdata[BIT_PARITY] ==
                  odd_parity(access_i.wdata[7:1])); // [RL12]

   always_comb
   begin
      next_ctrl = ctrl;
      next_latched_flag = latched_flag;
      next_filt_cnt = filt_cnt;
      next_parity_error = access_i.wr && !wr_ok; // [RL12]
      if (wr_ok)
      begin
         next_ctrl = access_i.wdata & WRITE_MASK; // [RL11]
      end
      // Filter restarts on every dip so short glitches never count
      if (pump_low_i)
      begin
         next_filt_cnt = '0;
      end
      else if (!recovered)
      begin
         next_filt_cnt = filt_cnt + 1'b1; // [RL7]
      end
      // Set beats clear when both land in one cycle
      if (pump_low_i)
      begin
         next_latched_flag = 1'b1; // [RL5]
      end
      else if (access_i.clr_pump_flag && recovered)
      begin
         next_latched_flag = 1'b0; // [RL7]
      end
      next_rdata = {ctrl[7:3], 2'b00, 1'b0}; // [RL11]
      next_rdata[BIT_PARITY] = odd_parity(next_rdata[7:1]); // [RL12]
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ctrl <= CTRL_RESET;
         latched_flag <= 1'b0;
         filt_cnt <= '0;
         // Reset image already carries valid parity for a cleared byte
         rdata_o <= {CTRL_RESET[7:1], ~^CTRL_RESET[7:1]};
         parity_error_o <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         latched_flag <= next_latched_flag;
         filt_cnt <= next_filt_cnt;
         rdata_o <= next_rdata;
         parity_error_o <= next_parity_error;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_comb
   begin
      if (ctrl[BIT_PUMP_POLICY])
      begin
         pump_undervoltage_flag_o = pump_low_i; // [RL3]
         ctrl_o.outputs_allowed = recovered; // [RL4]
      end
      else
      begin
         pump_undervoltage_flag_o = latched_flag; // [RL5]
         ctrl_o.outputs_allowed = !latched_flag; // [RL6]
      end
      ctrl_o.ol_check_active = ctrl[BIT_OL_CHECK] && !output_enable_bit_i; // [RL1]
      ctrl_o.ol_thresh_sel = ctrl[BIT_OL_THRESH]; // [RL2]
      ctrl_o.dither_disable = ctrl[BIT_DITHER_DIS]; // [RL8]
      ctrl_o.ov_thresh_sel = ctrl[BIT_OV_SELECT]; // [RL9]
      // Fail-safe released and no watchdog fault
      output_enable_writable_o = failsafe_input_n_i && !watchdog_fault_flag_i; // [RL10]
   end

   // ****************************************
   // Assertion helpers
   // ****************************************
   // Own count of clean pump cycles, saturating so it never wraps
   logic [FILT_W-1:0] ok_run;
   logic [FILT_W-1:0] next_ok_run;

   always_comb
   begin
      next_ok_run = ok_run;
      if (pump_low_i)
      begin
         next_ok_run = '0;
      end
      else if (ok_run != {FILT_W{1'b1}})
      begin
         next_ok_run = ok_run + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ok_run <= '0;
      end
      else
      begin
         ok_run <= next_ok_run;
      end
   end

   // Pump has stayed clean for the whole filter time
   sequence s_long_recovery;
      ok_run >= FILTER_CYC[FILT_W-1:0];
   endsequence
   // Host clear while the pump is still clean
   sequence s_host_clear;
      access_i.clr_pump_flag && !pump_low_i;
   endsequence

   // ****************************************
   // Assertions
   // ****************************************
   a_ol_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL1]
      output_enable_bit_i |-> !ctrl_o.ol_check_active)
      else $error("open-load check active with outputs enabled");
   a_thresh_follow: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL2]
      wr_ok |=> ctrl_o.ol_thresh_sel == $past(access_i.wdata[6]))
      else $error("threshold select not stored");
   a_flag_live: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL3]
      ctrl[BIT_PUMP_POLICY] |-> pump_undervoltage_flag_o == pump_low_i)
      else $error("live flag mismatch");
   a_auto_recover: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL4]
      s_long_recovery ##0 ctrl[BIT_PUMP_POLICY] |-> ctrl_o.outputs_allowed)
      else $error("outputs not restored");
   a_flag_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL5]
      pump_low_i |=> latched_flag)
      else $error("flag not latched");
   a_latched_off: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL6]
      (!ctrl[BIT_PUMP_POLICY] && latched_flag) |-> !ctrl_o.outputs_allowed)
      else $error("outputs on while flag latched");
   a_early_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL7]
      (latched_flag && !recovered) |=> latched_flag)
      else $error("flag cleared before filter");
   a_clear_release: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL7]
      s_long_recovery ##0 s_host_clear |=> !latched_flag)
      else $error("flag kept after filtered clear");
   a_dither: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL8]
      wr_ok |=> ctrl_o.dither_disable == $past(access_i.wdata[4]))
      else $error("dither bit not stored");
   a_ov_sel: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL9]
      wr_ok |=> ctrl_o.ov_thresh_sel == $past(access_i.wdata[3]))
      else $error("overvoltage select not stored");
   a_oe_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL10]
      !failsafe_input_n_i |-> !output_enable_writable_o)
      else $error("enable writable under fail-safe");
   a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL11]
      rdata_o[2:1] == 2'b00)
      else $error("reserved bits nonzero");
   a_parity_rd: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL12]
      ^rdata_o == 1'b1)
      else $error("read parity wrong");
   a_parity_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL12]
      (access_i.wr && !wr_ok) |=> parity_error_o)
      else $error("bad parity write not flagged");
   a_bad_write_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RL12]
      (access_i.wr && !wr_ok) |=> $stable(ctrl))
      else $error("bad parity write stored");
endmodule

// >>> tb/bclb_host_model.sv
/* Host model: register writes and flag clears.
   Assumes strobes sampled on rising ref_clk_i. */
module bclb_host_model (
   input wire logic ref_clk_i,
   output bclb_pkg::bclb_access_t access_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import bclb_pkg::*;
   initial access_o = '0;
   // ****************************************
   // Transfers
   // ****************************************
   // Bad flips parity to provoke a refusal
   task automatic write(input logic [7:0] d, input logic bad);
      @(posedge ref_clk_i);
      access_o.wdata <= {d[7:1], (~^d[7:1]) ^ bad};
      access_o.wr <= 1'b1;
      @(posedge ref_clk_i);
      access_o.wr <= 1'b0;
      access_o.wdata <= ~access_o.wdata;
   endtask
   task automatic clear();
      @(posedge ref_clk_i);
      access_o.clr_pump_flag <= 1'b1;
      @(posedge ref_clk_i);
      access_o.clr_pump_flag <= 1'b0;
   endtask
endmodule

// >>> tb/bridge_ctrl_low_byte_tb_top.sv
/* Self-checking bench for the control low byte.
   Assumes the host model drives access_i. */
module bridge_ctrl_low_byte_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bclb_pkg::*;
   localparam int unsigned FC = 6;
   logic ref_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic oe = 1'b0, fs_n = 1'b1, wdg = 1'b0, pl = 1'b0;
   logic [7:0] rdata, d;
   logic perr, flag, wrt;
   bclb_access_t acc;
   bclb_ctrl_t ctrl;
   int failures = 0;
   int tests_run = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   bclb_host_model host_u (.ref_clk_i(ref_clk_i), .access_o(acc));
   bclb_ctrl_low #(.FILTER_CYC(FC)) dut_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .access_i(acc), .output_enable_bit_i(oe), .failsafe_input_n_i(fs_n),
      .watchdog_fault_flag_i(wdg), .pump_low_i(pl), .rdata_o(rdata),
      .parity_error_o(perr), .pump_undervoltage_flag_o(flag),
      .output_enable_writable_o(wrt), .ctrl_o(ctrl));
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] rd_img(input logic [7:0] r);
      return {r[7:3], 2'b00, ~^r[7:3]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (failures == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic pump(input logic v);
      @(posedge ref_clk_i);
      pl <= v;
   endtask
   task automatic neg(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      #20000;
      failures++;
      summarize();
   end
   initial
   begin
      void'($urandom(66));
      repeat (6) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      neg(1);
      chk(rdata, 8'h01);
      // Latched mode: early clear must be refused
      pump(1'b1);
      neg(2);
      chk({6'h0, flag, ctrl.outputs_allowed}, 8'h02);
      pump(1'b0);
      host_u.clear();
      neg(1);
      chk({6'h0, flag, ctrl.outputs_allowed}, 8'h02);
      repeat (FC + 2) @(posedge ref_clk_i);
      host_u.clear();
      neg(1);
      chk({6'h0, flag, ctrl.outputs_allowed}, 8'h01);
      // Auto-recover policy
      host_u.write(8'h20, 1'b0);
      pump(1'b1);
      neg(2);
      chk({6'h0, flag, ctrl.outputs_allowed}, 8'h02);
      pump(1'b0);
      neg(1);
      chk({7'h0, flag}, 8'h00);
      repeat (FC + 2) @(posedge ref_clk_i);
      neg(1);
      chk({7'h0, ctrl.outputs_allowed}, 8'h01);
      // Latch was set during the live dip; clear it before policy flips
      host_u.clear();
      // Random writes, with a bad-parity write after every fourth good write
      for (int i = 0; i < 24; i++)
      begin
         d = 8'($urandom);
         @(posedge ref_clk_i);
         oe <= 1'($urandom);
         fs_n <= 1'($urandom);
         wdg <= 1'($urandom);
         host_u.write(d, 1'b0);
         neg(1);
         chk({3'h0, ctrl}, {3'h0, d[7] & ~oe, d[6], d[4], d[3], 1'b1});
         chk({6'h0, wrt, perr}, {6'h0, fs_n & ~wdg, 1'b0});
         neg(1);
         chk(rdata, rd_img(d));
         if (i % 4 == 3)
         begin
            host_u.write(~d, 1'b1);
            neg(1);
            chk({7'h0, perr}, 8'h01);
            neg(1);
            chk(rdata, rd_img(d));
         end
      end
      summarize();
   end
endmodule
